// [cfa_file_cmd.sv]
`timescale 1ns/1ps
`default_nettype none

module cfa_file_cmd
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Command frame
   input  wire logic       cmd_valid,
   output var  logic       cmd_ready,
   input  wire logic [1:0] cmd_code,
   input  wire logic [7:0] cmd_p1,
   input  wire logic [7:0] cmd_p2,
   input  wire logic [7:0] cmd_p3,
   // Write data stream
   input  wire logic       wr_valid,
   output var  logic       wr_ready,
   input  wire logic [7:0] wr_data,
   // Response data stream
   output var  logic       rsp_valid,
   input  wire logic       rsp_ready,
   output var  logic [7:0] rsp_data,
   // Completion
   output var  logic       done,
   output var  logic [2:0] done_status,
   // Application indications
   output var  logic       app_init_ind,
   output var  logic       app_term_ind,
   output var  logic [1:0] status_rsp_kind,
   // File environment
   input  wire logic       read_granted,
   input  wire logic       update_granted,
   input  wire logic       rec_cyclic,
   input  wire logic [4:0] tf_sfi,
   input  wire logic [4:0] rf_sfi,
   input  wire logic       ef_reselect,
   // File content loading
   input  wire logic       load_valid,
   input  wire logic       load_rec,
   input  wire logic [7:0] load_addr,
   input  wire logic [7:0] load_data,
   // Record pointer state
   output var  logic [3:0] rec_ptr,
   output var  logic       rec_ptr_set
);

   logic [7:0]  tf_mem  [0:cfa_pkg::TF_SIZE-1];
   logic [7:0]  rec_mem [0:(cfa_pkg::REC_NUM*cfa_pkg::REC_LEN)-1];

   cfa_pkg::cfa_state_e state_reg;
   logic [14:0] addr_reg;
   logic [8:0]  len_reg;
   logic [8:0]  cnt_reg;
   logic        src_rec_reg;

   // Decode results
   logic [2:0]  dec_status;
   logic        dec_go_read;
   logic        dec_go_write;
   logic        dec_src_rec;
   logic [14:0] dec_addr;
   logic [8:0]  dec_len;
   logic [3:0]  dec_rec;
   logic        dec_ptr_upd;
   logic [1:0]  dec_kind;
   logic        dec_init;
   logic        dec_term;
   logic [14:0] tr_off;
   logic        tr_sfi_ok;
   logic        tr_param_ok;
   logic [8:0]  tr_len;
   logic [15:0] tr_end;
   logic [2:0]  rec_mode;
   logic [4:0]  rec_sfi;

   logic        cmd_fire;
   logic        wr_fire;
   logic        buf_in_ready;
   logic        buf_push;
   logic [7:0]  rd_byte;
   logic        last_byte;

   assign cmd_fire  = cmd_valid && cmd_ready;
   assign wr_fire   = wr_valid && wr_ready;
   assign last_byte = (cnt_reg == (len_reg - 9'h001));
   assign buf_push  = (state_reg == cfa_pkg::ST_READ);
   assign rd_byte   = src_rec_reg ? rec_mem[addr_reg[cfa_pkg::REC_AW-1:0]]
                                  : tf_mem[addr_reg[cfa_pkg::TF_AW-1:0]];

   always_comb
   begin
      dec_status  = cfa_pkg::STS_OK;
      dec_go_read = 1'b0;
      dec_go_write = 1'b0;
      dec_src_rec = 1'b0;
      dec_addr    = 15'h0000;
      dec_len     = 9'h000;
      dec_rec     = rec_ptr;
      dec_ptr_upd = 1'b0;
      dec_kind    = cfa_pkg::KIND_NONE;
      dec_init    = 1'b0;
      dec_term    = 1'b0;
      tr_off      = {cmd_p1[6:0], cmd_p2};
      tr_sfi_ok   = 1'b1;
      tr_param_ok = 1'b1;
      if (cmd_p1[cfa_pkg::TR_SFI_FLAG])
      begin
         tr_off      = {7'h00, cmd_p2};
         tr_param_ok = (cmd_p1[7:5] == cfa_pkg::TR_SFI_CODE);
         tr_sfi_ok   = (cmd_p1[4:0] == tf_sfi) && (tf_sfi != 5'h00);
      end
      // Zero length byte means the full short length
      tr_len   = (cmd_p3 == 8'h00) ? cfa_pkg::LEN_MAX : {1'b0, cmd_p3};
      tr_end   = {1'b0, tr_off} + {7'h00, tr_len};
      rec_mode = cmd_p2[2:0];
      rec_sfi  = cmd_p2[7:3];
      case (cmd_code)
         cfa_pkg::CMD_STATUS:
         begin
            if (cmd_p1 > cfa_pkg::APP_TERM)
               dec_status = cfa_pkg::STS_PARAM;
            else if (cmd_p2 == cfa_pkg::STAT_SEL_RSP)
               dec_kind = cfa_pkg::KIND_SELECT;
            else if (cmd_p2 == cfa_pkg::STAT_NAME_RSP)
               dec_kind = cfa_pkg::KIND_NAME;
            else if (cmd_p2 != cfa_pkg::STAT_NO_DATA)
               dec_status = cfa_pkg::STS_PARAM;
            if (dec_status == cfa_pkg::STS_OK)
            begin
               dec_init = (cmd_p1 == cfa_pkg::APP_INIT);
               dec_term = (cmd_p1 == cfa_pkg::APP_TERM);
            end
         end
         cfa_pkg::CMD_TR_READ,
         cfa_pkg::CMD_TR_WRITE:
         begin
            // Same parameter decode for both directions
            dec_addr = tr_off;
            dec_len  = tr_len;
            if (!tr_param_ok)
               dec_status = cfa_pkg::STS_PARAM;
            else if (!tr_sfi_ok)
               dec_status = cfa_pkg::STS_NOFILE;
            else if ((cmd_code == cfa_pkg::CMD_TR_READ) && !read_granted)
               dec_status = cfa_pkg::STS_ACCESS;
            else if ((cmd_code == cfa_pkg::CMD_TR_WRITE) && !update_granted)
               dec_status = cfa_pkg::STS_ACCESS;
            else if ((cmd_code == cfa_pkg::CMD_TR_WRITE) && (cmd_p3 == 8'h00))
               dec_status = cfa_pkg::STS_LENGTH;
            else if (tr_end > cfa_pkg::TF_SIZE_W)
               dec_status = cfa_pkg::STS_RANGE;
            else if (cmd_code == cfa_pkg::CMD_TR_READ)
               dec_go_read = 1'b1;
            else
               dec_go_write = 1'b1;
         end
         default:
         begin
            dec_src_rec = 1'b1;
            dec_len     = cfa_pkg::REC_LEN_W;
            if (rec_sfi == cfa_pkg::SFI_RESERVED)
               dec_status = cfa_pkg::STS_PARAM;
            else if ((rec_mode != cfa_pkg::MODE_NEXT) && (rec_mode != cfa_pkg::MODE_PREV) &&
                     (rec_mode != cfa_pkg::MODE_ABS))
               dec_status = cfa_pkg::STS_PARAM;
            else if ((rec_sfi != cfa_pkg::SFI_CURRENT) && (rec_sfi != rf_sfi))
               dec_status = cfa_pkg::STS_NOFILE;
            else if (!read_granted)
               dec_status = cfa_pkg::STS_ACCESS;
            else if (tr_len != cfa_pkg::REC_LEN_W)
               dec_status = cfa_pkg::STS_LENGTH;
            else
            begin
               case (rec_mode)
                  cfa_pkg::MODE_NEXT:
                  begin
                     dec_ptr_upd = 1'b1;
                     if (!rec_ptr_set)
                        dec_rec = cfa_pkg::REC_FIRST;
                     else if (rec_ptr != cfa_pkg::REC_LAST)
                        dec_rec = rec_ptr + 4'h1;
                     else if (rec_cyclic)
                        dec_rec = cfa_pkg::REC_FIRST;
                     else
                     begin
                        dec_ptr_upd = 1'b0;
                        dec_status  = cfa_pkg::STS_NODATA;
                     end
                  end
                  cfa_pkg::MODE_PREV:
                  begin
                     dec_ptr_upd = 1'b1;
                     if (!rec_ptr_set)
                        dec_rec = cfa_pkg::REC_LAST;
                     else if (rec_ptr != cfa_pkg::REC_FIRST)
                        dec_rec = rec_ptr - 4'h1;
                     else if (rec_cyclic)
                        dec_rec = cfa_pkg::REC_LAST;
                     else
                     begin
                        dec_ptr_upd = 1'b0;
                        dec_status  = cfa_pkg::STS_NODATA;
                     end
                  end
                  default:
                  begin
                     if (cmd_p1 == cfa_pkg::REC_CUR_NUM)
                     begin
                        // Current record needs a pointer already set
                        if (!rec_ptr_set)
                           dec_status = cfa_pkg::STS_NODATA;
                     end
                     else if (cmd_p1 > {4'h0, cfa_pkg::REC_LAST})
                        dec_status = cfa_pkg::STS_RANGE;
                     else
                        dec_rec = cmd_p1[3:0];
                  end
               endcase
               if (dec_status == cfa_pkg::STS_OK)
               begin
                  dec_go_read = 1'b1;
                  dec_addr    = {8'h00, dec_rec[2:0] - 3'h1, 4'h0};
               end
               else
                  dec_ptr_upd = 1'b0;
            end
         end
      endcase
   end

   // Sequencing of the active command
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg   <= cfa_pkg::ST_IDLE;
         cmd_ready   <= 1'b1;
         wr_ready    <= 1'b0;
         addr_reg    <= 15'h0000;
         len_reg     <= 9'h000;
         cnt_reg     <= 9'h000;
         src_rec_reg <= 1'b0;
         done        <= 1'b0;
         done_status <= cfa_pkg::STS_OK;
      end
      else
      begin
         done <= 1'b0;
         case (state_reg)
            cfa_pkg::ST_IDLE:
            begin
               if (cmd_fire)
               begin
                  addr_reg    <= dec_addr;
                  len_reg     <= dec_len;
                  cnt_reg     <= 9'h000;
                  src_rec_reg <= dec_src_rec;
                  done_status <= dec_status;
                  if (dec_go_read)
                  begin
                     state_reg <= cfa_pkg::ST_READ;
                     cmd_ready <= 1'b0;
                  end
                  else if (dec_go_write)
                  begin
                     state_reg <= cfa_pkg::ST_WRITE;
                     cmd_ready <= 1'b0;
                     wr_ready  <= 1'b1;
                  end
                  else
                     done <= 1'b1;
               end
            end
            cfa_pkg::ST_READ:
            begin
               if (buf_in_ready)
               begin
                  addr_reg <= addr_reg + 15'h0001;
                  cnt_reg  <= cnt_reg + 9'h001;
                  if (last_byte)
                  begin
                     state_reg <= cfa_pkg::ST_IDLE;
                     cmd_ready <= 1'b1;
                     done      <= 1'b1;
                  end
               end
            end
            cfa_pkg::ST_WRITE:
            begin
               if (wr_fire)
               begin
                  addr_reg <= addr_reg + 15'h0001;
                  cnt_reg  <= cnt_reg + 9'h001;
                  if (last_byte)
                  begin
                     state_reg <= cfa_pkg::ST_IDLE;
                     cmd_ready <= 1'b1;
                     wr_ready  <= 1'b0;
                     done      <= 1'b1;
                  end
               end
            end
            default:
            begin
               state_reg <= cfa_pkg::ST_IDLE;
               cmd_ready <= 1'b1;
               wr_ready  <= 1'b0;
            end
         endcase
      end
   end

   // File contents; loading only while no command runs
   always_ff @(posedge clk)
   begin
      if (wr_fire)
         tf_mem[addr_reg[cfa_pkg::TF_AW-1:0]] <= wr_data;
      else if (load_valid && !load_rec && (state_reg == cfa_pkg::ST_IDLE))
         tf_mem[load_addr] <= load_data;
      if (load_valid && load_rec && (state_reg == cfa_pkg::ST_IDLE))
         rec_mem[load_addr[cfa_pkg::REC_AW-1:0]] <= load_data;
   end

   // Record pointer; a new file selection forgets it, but only in idle with no command accepted in that cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rec_ptr     <= cfa_pkg::PTR_RESET;
         rec_ptr_set <= 1'b0;
      end
      else if (cmd_fire && dec_ptr_upd)
      begin
         rec_ptr     <= dec_rec;
         rec_ptr_set <= 1'b1;
      end
      else if (ef_reselect && (state_reg == cfa_pkg::ST_IDLE) && !cmd_fire)
      begin
         rec_ptr     <= cfa_pkg::PTR_RESET;
         rec_ptr_set <= 1'b0;
      end
   end

   // Indications toward the selected application
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         app_init_ind    <= 1'b0;
         app_term_ind    <= 1'b0;
         status_rsp_kind <= cfa_pkg::KIND_NONE;
      end
      else
      begin
         app_init_ind <= cmd_fire && (cmd_code == cfa_pkg::CMD_STATUS) && dec_init;
         app_term_ind <= cmd_fire && (cmd_code == cfa_pkg::CMD_STATUS) && dec_term;
         if (cmd_fire && (cmd_code == cfa_pkg::CMD_STATUS) &&
             (dec_status == cfa_pkg::STS_OK))
            status_rsp_kind <= dec_kind;
      end
   end

   // Receiver stall holds the read sequencer, no byte is lost
   cfa_skid_buf u_rsp_buf
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (buf_push),
      .in_ready  (buf_in_ready),
      .in_data   (rd_byte),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  (rsp_data)
   );

endmodule // cfa_file_cmd

`default_nettype wire

// [cfa_pkg.sv]
`default_nettype none
package cfa_pkg;

   // Command codes on the command port
   localparam logic [1:0] CMD_STATUS     = 2'h0;
   localparam logic [1:0] CMD_TR_READ    = 2'h1;
   localparam logic [1:0] CMD_TR_WRITE   = 2'h2;
   localparam logic [1:0] CMD_REC_READ   = 2'h3;

   // Completion codes
   localparam logic [2:0] STS_OK         = 3'h0;
   localparam logic [2:0] STS_PARAM      = 3'h1;
   localparam logic [2:0] STS_ACCESS     = 3'h2;
   localparam logic [2:0] STS_NOFILE     = 3'h3;
   localparam logic [2:0] STS_RANGE      = 3'h4;
   localparam logic [2:0] STS_NODATA     = 3'h5;
   localparam logic [2:0] STS_LENGTH     = 3'h6;

   // Status command first parameter byte
   localparam logic [7:0] APP_NO_IND     = 8'h00;
   localparam logic [7:0] APP_INIT       = 8'h01;
   localparam logic [7:0] APP_TERM       = 8'h02;

   // Status command second parameter byte
   localparam logic [7:0] STAT_SEL_RSP   = 8'h00;
   localparam logic [7:0] STAT_NAME_RSP  = 8'h01;
   localparam logic [7:0] STAT_NO_DATA   = 8'h0C;

   // Response kind reported for a status command
   localparam logic [1:0] KIND_NONE      = 2'h0;
   localparam logic [1:0] KIND_SELECT    = 2'h1;
   localparam logic [1:0] KIND_NAME      = 2'h2;

   // Transparent first parameter byte fields
   localparam int         TR_SFI_FLAG    = 7;
   localparam logic [2:0] TR_SFI_CODE    = 3'h4;

   // Record read parameter byte fields: mode and SFI in the second byte, current record number in the first
   localparam logic [2:0] MODE_NEXT      = 3'h2;
   localparam logic [2:0] MODE_PREV      = 3'h3;
   localparam logic [2:0] MODE_ABS       = 3'h4;
   localparam logic [4:0] SFI_CURRENT    = 5'h00;
   localparam logic [4:0] SFI_RESERVED   = 5'h1F;
   localparam logic [7:0] REC_CUR_NUM    = 8'h00;

   // File geometry
   localparam int         TF_SIZE        = 256;
   localparam int         TF_AW          = 8;
   localparam int         REC_NUM        = 8;
   localparam int         REC_LEN        = 16;
   localparam int         REC_AW         = 7;
   localparam logic [3:0] REC_FIRST      = 4'h1;
   localparam logic [3:0] REC_LAST       = 4'h8;
   localparam logic [8:0] LEN_MAX        = 9'h100;
   localparam logic [8:0] REC_LEN_W      = 9'h010;
   localparam logic [15:0] TF_SIZE_W     = 16'h0100;

   // Reset values
   localparam logic [3:0] PTR_RESET      = 4'h0;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } cfa_state_e;

endpackage

`default_nettype wire

// [cfa_skid_buf.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer, outputs straight from flops
module cfa_skid_buf
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Filling side
   input  wire logic       in_valid,
   output var  logic       in_ready,
   input  wire logic [7:0] in_data,
   // Draining side
   output var  logic       out_valid,
   input  wire logic       out_ready,
   output var  logic [7:0] out_data
);

   logic       sk_valid_reg;
   logic [7:0] sk_data_reg;

   // Ready is registered so the filler never sees a combinational path
   assign in_ready = !sk_valid_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid    <= 1'b0;
         out_data     <= 8'h00;
         sk_valid_reg <= 1'b0;
         sk_data_reg  <= 8'h00;
      end
      else if (out_ready || !out_valid)
      begin
         if (sk_valid_reg)
         begin
            out_valid    <= 1'b1;
            out_data     <= sk_data_reg;
            sk_valid_reg <= 1'b0;
         end
         else
         begin
            out_valid <= in_valid;
            out_data  <= in_data;
         end
      end
      else if (in_valid && !sk_valid_reg)
      begin
         sk_valid_reg <= 1'b1;
         sk_data_reg  <= in_data;
      end
   end

endmodule // cfa_skid_buf

`default_nettype wire

// [cfa_file_cmd_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cfa_file_cmd_chk
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Command
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic [1:0] cmd_code,
   input wire logic [7:0] cmd_p1,
   input wire logic [7:0] cmd_p2,
   input wire logic [7:0] cmd_p3,
   // Response stream
   input wire logic       rsp_valid,
   input wire logic       rsp_ready,
   input wire logic [7:0] rsp_data,
   // Results and environment
   input wire logic       done,
   input wire logic [2:0] done_status,
   input wire logic       app_init_ind,
   input wire logic       app_term_ind,
   input wire logic [1:0] status_rsp_kind,
   input wire logic       read_granted,
   input wire logic       update_granted,
   input wire logic [3:0] rec_ptr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic tk = cmd_valid && cmd_ready;
   wire logic st = tk && cmd_code == cfa_pkg::CMD_STATUS;
   wire logic rc = tk && cmd_code == cfa_pkg::CMD_REC_READ;
   AST_ST_DONE: assert property (st |=> done)
      else $error("status command not finished next cycle");
   AST_INIT: assert property (st && cmd_p1 == 8'h01 && cmd_p2 == 8'h00 |=> app_init_ind)
      else $error("init indication missing");
   AST_TERM: assert property (app_term_ind |-> $past(st && cmd_p1 == 8'h02))
      else $error("termination indication without cause");
   AST_KIND: assert property (st && cmd_p1 == 8'h00 && cmd_p2 == 8'h01
      |=> status_rsp_kind == cfa_pkg::KIND_NAME)
      else $error("status response kind wrong");
   AST_PARAM: assert property (st && cmd_p1 > 8'h02 |=> done_status == cfa_pkg::STS_PARAM
      && !app_init_ind && !app_term_ind)
      else $error("reserved status coding not refused");
   AST_ABS_PTR: assert property (rc && cmd_p2[2:0] == 3'h4 |=> $stable(rec_ptr))
      else $error("absolute or current read moved pointer");
   AST_REC_DENY: assert property (rc && !read_granted && cmd_p2 == 8'h02
      |=> done && done_status == cfa_pkg::STS_ACCESS && $stable(rec_ptr))
      else $error("record read without access");
   AST_TR_DENY: assert property (tk && cmd_code == cfa_pkg::CMD_TR_READ && !read_granted
      && cmd_p1 == 8'h00 && cmd_p3 == 8'h01 |=> done ##1 !rsp_valid)
      else $error("transparent read without access");
   AST_WR_DENY: assert property (tk && cmd_code == cfa_pkg::CMD_TR_WRITE && !update_granted
      && cmd_p1 == 8'h00 && cmd_p2 < 8'hF0 && cmd_p3 == 8'h02
      |=> done && done_status == cfa_pkg::STS_ACCESS)
      else $error("write without access");
   AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready
      |=> rsp_valid && $stable(rsp_data))
      else $error("response byte lost under stall");
   COV_TERM: cover property (st ##1 app_term_ind);
   COV_STALL: cover property ((rsp_valid && !rsp_ready) [*2]);
   COV_NODATA: cover property (done && done_status == cfa_pkg::STS_NODATA);
endmodule // cfa_file_cmd_chk
bind cfa_file_cmd cfa_file_cmd_chk i_cfa_file_cmd_chk
(
   .clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_code, .cmd_p1, .cmd_p2, .cmd_p3,
   .rsp_valid, .rsp_ready, .rsp_data, .done, .done_status, .app_init_ind,
   .app_term_ind, .status_rsp_kind, .read_granted, .update_granted, .rec_ptr
);
`default_nettype wire

// [cfa_term_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cfa_term_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Response sink
   input  wire logic       rsp_valid,
   output var  logic       rsp_ready,
   input  wire logic [7:0] rsp_data,
   // Write data source
   output var  logic       wr_valid,
   input  wire logic       wr_ready,
   output var  logic [7:0] wr_data
);
   logic [7:0] got [$];
   logic       stall, wen;
   logic [7:0] wbase, widx;
   logic [1:0] cnt;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt  <= 2'h0;
         widx <= 8'h00;
      end
      else
      begin
         cnt <= cnt + 2'h1;
         if (rsp_valid && rsp_ready)
            got.push_back(rsp_data);
         widx <= !wen ? 8'h00 : widx + 8'(wr_valid && wr_ready);
      end
   end
   // Slow mode accepts one byte in four
   assign rsp_ready = !stall || cnt == 2'h3;
   assign wr_valid  = wen;
   // Idle data line keeps moving so a stale byte cannot pass
   assign wr_data   = wen ? wbase + widx : {6'h00, cnt};
endmodule // cfa_term_model
`default_nettype wire

// [cfa_file_cmd_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cfa_file_cmd_tb;
   logic       clk, rst_n, cmd_valid, cmd_ready, wr_valid, wr_ready, rsp_valid, rsp_ready;
   logic       done, app_init_ind, app_term_ind, read_granted, update_granted, rec_cyclic;
   logic       ef_reselect, load_valid, load_rec, rec_ptr_set;
   logic [1:0] cmd_code, status_rsp_kind, ind, kind;
   logic [2:0] done_status, st;
   logic [3:0] rec_ptr;
   logic [4:0] tf_sfi, rf_sfi;
   logic [7:0] cmd_p1, cmd_p2, cmd_p3, wr_data, rsp_data, load_addr, load_data;
   logic [7:0] tf [256];
   int         errors, samples_checked;
   cfa_file_cmd i_cfa_file_cmd
   (
      .clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_code, .cmd_p1, .cmd_p2, .cmd_p3,
      .wr_valid, .wr_ready, .wr_data, .rsp_valid, .rsp_ready, .rsp_data, .done,
      .done_status, .app_init_ind, .app_term_ind, .status_rsp_kind, .read_granted,
      .update_granted, .rec_cyclic, .tf_sfi, .rf_sfi, .ef_reselect, .load_valid,
      .load_rec, .load_addr, .load_data, .rec_ptr, .rec_ptr_set
   );
   cfa_term_model i_cfa_term_model
   (
      .clk, .rst_n, .rsp_valid, .rsp_ready, .rsp_data, .wr_valid, .wr_ready, .wr_data
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cs(input logic [2:0] e);
      chk("status", {5'h00, e}, {5'h00, st});
   endtask
   // Issue one command at a falling edge, wait for finish and drain
   task automatic run(input logic [1:0] c, input logic [7:0] a, b, d);
      int n;
      n = 0;
      i_cfa_term_model.got.delete();
      {cmd_code, cmd_p1, cmd_p2, cmd_p3} = {c, a, b, d};
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 600)
      begin
         @(negedge clk);
         n++;
      end
      {st, ind, kind} = {done_status, app_term_ind, app_init_ind, status_rsp_kind};
      while (rsp_valid === 1'b1 && n < 600)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 600)
      begin
         errors++;
         $display("BAD timeout expected done seen none");
         end_sim();
      end
   endtask
   task automatic cmp(input int off, len, input logic rec);
      chk("count", 8'(len), 8'(i_cfa_term_model.got.size()));
      for (int i = 0; i < len && i < i_cfa_term_model.got.size(); i++)
         chk("byte", rec ? 8'(off + i) : tf[off + i], i_cfa_term_model.got[i]);
   endtask
   task automatic tr(input logic [7:0] a, b, d, input logic [2:0] es, input int off, len);
      run(cfa_pkg::CMD_TR_READ, a, b, d);
      cs(es);
      cmp(off, len, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, b, d, input logic [2:0] es, input int off);
      i_cfa_term_model.wbase = b + 8'h80;
      i_cfa_term_model.wen = 1'b1;
      run(cfa_pkg::CMD_TR_WRITE, a, b, d);
      i_cfa_term_model.wen = 1'b0;
      // Model's byte index clears only on an edge with the source off
      @(negedge clk);
      cs(es);
      if (es == cfa_pkg::STS_OK)
         for (int i = 0; i < d; i++)
            tf[off + i] = b + 8'h80 + 8'(i);
   endtask
   task automatic rr(input logic [7:0] a, b, input logic [2:0] es, input logic [3:0] ep, int n);
      run(cfa_pkg::CMD_REC_READ, a, b, 8'h10);
      cs(es);
      chk("pointer", {4'h0, ep}, {4'h0, rec_ptr});
      cmp(n * 16 - 16, n > 0 ? 16 : 0, 1'b1);
   endtask
   task automatic reselect;
      ef_reselect = 1'b1;
      @(negedge clk);
      ef_reselect = 1'b0;
   endtask
   initial
   begin
      {errors, samples_checked} = '0;
      {rst_n, cmd_valid, cmd_code, cmd_p1, cmd_p2, cmd_p3, rec_cyclic, ef_reselect} = '0;
      {load_valid, load_rec, load_addr, load_data, read_granted, update_granted} = 2'h3;
      {tf_sfi, rf_sfi} = {5'h05, 5'h09};
      {i_cfa_term_model.stall, i_cfa_term_model.wen, i_cfa_term_model.wbase} = '0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      // Memories have no reset, so both are loaded first
      for (int i = 0; i < 384; i++)
      begin
         {load_valid, load_rec, load_addr} = {1'b1, i > 255, 8'(i)};
         load_data = (i > 255) ? 8'(i) : 8'(i) ^ 8'h5A;
         if (i < 256)
            tf[i] = load_data;
         @(negedge clk);
      end
      load_valid = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         run(cfa_pkg::CMD_STATUS, 8'(i), 8'h00, 8'h00);
         cs(i < 3 ? cfa_pkg::STS_OK : cfa_pkg::STS_PARAM);
         chk("indication", 8'(i < 3 ? i : 0), {6'h00, ind});
         run(cfa_pkg::CMD_STATUS, 8'h00, i[0] ? 8'h0C : 8'h01, 8'hFF);
         chk("kind", {6'h00, i[0] ? cfa_pkg::KIND_NONE : cfa_pkg::KIND_NAME}, {6'h00, kind});
      end
      run(cfa_pkg::CMD_STATUS, 8'h00, 8'h00, 8'h00);
      chk("kind", 8'h01, {6'h00, kind});
      run(cfa_pkg::CMD_STATUS, 8'h00, 8'h02, 8'h00);
      cs(cfa_pkg::STS_PARAM);
      chk("kind", 8'h01, {6'h00, kind});
      i_cfa_term_model.stall = 1'b1;
      tr(8'h00, 8'hFE, 8'h02, cfa_pkg::STS_OK, 254, 2);
      tr(8'h01, 8'h00, 8'h01, cfa_pkg::STS_RANGE, 0, 0);
      tr(8'h85, 8'h10, 8'h03, cfa_pkg::STS_OK, 16, 3);
      tr(8'hA0, 8'h00, 8'h01, cfa_pkg::STS_PARAM, 0, 0);
      tr(8'h86, 8'h00, 8'h01, cfa_pkg::STS_NOFILE, 0, 0);
      read_granted = 1'b0;
      tr(8'h00, 8'h00, 8'h01, cfa_pkg::STS_ACCESS, 0, 0);
      read_granted = 1'b1;
      wr(8'h00, 8'h20, 8'h04, cfa_pkg::STS_OK, 32);
      wr(8'h85, 8'h30, 8'h02, cfa_pkg::STS_OK, 48);
      update_granted = 1'b0;
      wr(8'h00, 8'h40, 8'h02, cfa_pkg::STS_ACCESS, 64);
      update_granted = 1'b1;
      wr(8'h00, 8'h40, 8'h00, cfa_pkg::STS_LENGTH, 64);
      tr(8'h00, 8'h20, 8'h28, cfa_pkg::STS_OK, 32, 40);
      i_cfa_term_model.stall = 1'b0;
      reselect();
      chk("ptr_set", 8'h00, {7'h00, rec_ptr_set});
      rr(8'h00, 8'h04, cfa_pkg::STS_NODATA, 0, 0);
      rr(8'h00, 8'h02, cfa_pkg::STS_OK, 1, 1);
      rr(8'h00, 8'h03, cfa_pkg::STS_NODATA, 1, 0);
      rr(8'h05, 8'h04, cfa_pkg::STS_OK, 1, 5);
      rr(8'h00, 8'h04, cfa_pkg::STS_OK, 1, 1);
      rr(8'h09, 8'h04, cfa_pkg::STS_RANGE, 1, 0);
      read_granted = 1'b0;
      rr(8'h00, 8'h02, cfa_pkg::STS_ACCESS, 1, 0);
      read_granted = 1'b1;
      rr(8'h00, {rf_sfi, 3'h2}, cfa_pkg::STS_OK, 2, 2);
      rr(8'h00, 8'h52, cfa_pkg::STS_NOFILE, 2, 0);
      rr(8'h00, 8'hFA, cfa_pkg::STS_PARAM, 2, 0);
      rr(8'h00, 8'h00, cfa_pkg::STS_PARAM, 2, 0);
      run(cfa_pkg::CMD_REC_READ, 8'h00, 8'h02, 8'h08);
      cs(cfa_pkg::STS_LENGTH);
      chk("pointer", 8'h02, {4'h0, rec_ptr});
      reselect();
      rr(8'h00, 8'h03, cfa_pkg::STS_OK, 8, 8);
      rr(8'h00, 8'h02, cfa_pkg::STS_NODATA, 8, 0);
      rec_cyclic = 1'b1;
      rr(8'h00, 8'h02, cfa_pkg::STS_OK, 1, 1);
      rr(8'h00, 8'h03, cfa_pkg::STS_OK, 8, 8);
      end_sim();
   end
endmodule // cfa_file_cmd_tb
`default_nettype wire
